// ==== design/irq_ctl_regs.vh ====
// irq_ctl_regs.vh: register offsets, bit positions and reset values
// for the core interrupt enable and flag block.
// assumes a 32-bit apb slave, one aligned word per register.
`ifndef IRQ_CTL_REGS_VH
`define IRQ_CTL_REGS_VH

// byte offsets
`define OFF_CTRL        8'h00
`define OFF_PERIPH_EN   8'h04
`define OFF_PIN_SEL     8'h08
`define OFF_T0_COUNT    8'h0c
`define OFF_FLAG_VIEW   8'h10

// interrupt_control bit positions
`define B_GLOBAL_EN     7
`define B_GROUP_EN      6
`define B_T0_OVF_EN     5
`define B_EXT_EN        4
`define B_CHG_EN        3
`define B_T0_OVF_FLAG   2
`define B_EXT_FLAG      1
`define B_CHG_FLAG      0

// peripheral_irq_enable_one bit positions
`define B_ADC_EN        6
`define B_COLL_EN       5
`define B_SER_EN        4
`define B_T2_EN         1
`define B_T1_EN         0

// implemented bits of peripheral_irq_enable_one
`define PERIPH_EN_MASK  8'h73
`define PERIPH_EN_RESET 8'h00
`define CTRL_RESET      1'b0
`define SEL_RESET       1'b0

// vector loaded into the program counter when a request is taken
`define IRQ_VECTOR      13'h0004
`define T0_COUNT_TOP    8'hff
`define T0_COUNT_STEP   8'h01

`endif

// ==== design/pin_event_detect.v ====
// pin_event_detect: two-flop synchroniser and edge detection per pin.
// assumes pins are asynchronous to pclk; outputs are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module pin_event_detect #(
  parameter N = 1
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // raw pins
  input  wire [N-1:0] pin,
  // events, one cycle each
  output wire [N-1:0] rise,
  output wire [N-1:0] fall
);

  reg [N-1:0] meta;
  reg [N-1:0] sync;
  reg [N-1:0] prev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {N{1'b0}};
      sync <= {N{1'b0}};
      prev <= {N{1'b0}};
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

endmodule

`default_nettype wire

// ==== design/irq_ctl.v ====
// irq_ctl: interrupt control and first peripheral enable registers,
// flag capture and the interrupt request to the core.
// assumes an apb master on pclk, peripheral flags on pclk, raw pins
// for the external interrupt and the change-monitored pins.
//
// Operation
// [R1] global enable 1 passes enabled interrupts, 0 blocks all
// [R2] peripheral group enable 1 passes enabled peripheral interrupts
// [R3] peripheral interrupts need group enable and their own enable
// [R4] timer0 overflow enable gates the timer0 overflow interrupt
// [R5] external pin enable gates the external pin interrupt
// [R6] pin change needs its enable and the per-pin select register
// [R7] timer0 rollover sets its flag, held until software writes 0
// [R8] timer0 counter keeps its value through reset
// [R9] external pin event sets its flag until software clears it
// [R10] pin change flag shows whether any monitored pin changed
// [R11] adc enable passes or masks the adc interrupt
// [R12] serial collision enable passes or masks collision interrupt
// [R13] serial port enable passes or masks serial port interrupt
// [R14] timer2 enable passes or masks timer2 interrupt
// [R15] timer1 enable passes or masks timer1 interrupt
// [R16] unused peripheral enable bits ignore writes and read zero
// [R17] taking an interrupt clears global enable and loads the vector
// [R18] return from interrupt sets global enable again
// [R19] edge select picks rising or falling external pin edge
// [R20] flags set regardless of their enables or global enable
// [R21] request when global enable and an enabled flag is pending
// [R22] reset clears control bits 7..1 and peripheral enables
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_regs.vh"

module irq_ctl #(
  parameter PINS = 6
) (
  // clock and reset
  input  wire            pclk,
  input  wire            presetn,
  // apb slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [7:0]      paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // event sources
  input  wire            timer0_tick,
  input  wire            ext_pin,
  input  wire            ext_edge_select,
  input  wire [PINS-1:0] change_pins,
  input  wire [7:0]      periph_flags,
  // core side
  input  wire            irq_taken,
  input  wire            return_from_irq,
  output reg             irq_request,
  output reg  [12:0]     irq_vector
);

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // control and flag state
  reg            global_irq_enable;
  reg            peripheral_group_enable;
  reg            timer0_overflow_enable;
  reg            ext_pin_irq_enable;
  reg            pin_change_enable;
  reg            timer0_overflow_flag;
  reg            ext_pin_irq_flag;
  reg            pin_change_flag;
  reg  [7:0]     peripheral_irq_enable_one;
  reg  [PINS-1:0] pin_change_select_reg;
  reg  [7:0]     timer0_counter;

  wire [PINS-1:0] chg_rise;
  wire [PINS-1:0] chg_fall;
  wire            ext_rise;
  wire            ext_fall;

  // apb decode
  wire access   = psel & penable & pready;
  wire wr       = access & pwrite;
  wire wr_ctl   = wr & hit(paddr, `OFF_CTRL);
  wire wr_pie   = wr & hit(paddr, `OFF_PERIPH_EN);
  wire wr_sel   = wr & hit(paddr, `OFF_PIN_SEL);
  wire wr_cnt   = wr & hit(paddr, `OFF_T0_COUNT);
  wire mapped   = hit(paddr, `OFF_CTRL) | hit(paddr, `OFF_PERIPH_EN) |
                  hit(paddr, `OFF_PIN_SEL) | hit(paddr, `OFF_T0_COUNT) |
                  hit(paddr, `OFF_FLAG_VIEW);

  // events
  wire t0_roll   = timer0_tick & (timer0_counter == `T0_COUNT_TOP);
  wire ext_evt   = ext_edge_select ? ext_rise : ext_fall; // [R19]
  wire pin_evt   = |((chg_rise | chg_fall) & pin_change_select_reg); // [R6]

  pin_event_detect #(.N(1)) u_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  pin_event_detect #(.N(PINS)) u_chg (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (change_pins),
    .rise    (chg_rise),
    .fall    (chg_fall)
  );

  // interrupt_control bits 7..1 and enables
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable       <= `CTRL_RESET; // [R22]
      peripheral_group_enable <= `CTRL_RESET;
      timer0_overflow_enable  <= `CTRL_RESET;
      ext_pin_irq_enable      <= `CTRL_RESET;
      pin_change_enable       <= `CTRL_RESET;
      timer0_overflow_flag    <= `CTRL_RESET;
      ext_pin_irq_flag        <= `CTRL_RESET;
      peripheral_irq_enable_one <= `PERIPH_EN_RESET; // [R22]
      pin_change_select_reg   <= {PINS{`SEL_RESET}};
    end else begin
      if (wr_ctl) begin
        global_irq_enable       <= pwdata[`B_GLOBAL_EN];
        peripheral_group_enable <= pwdata[`B_GROUP_EN];
        timer0_overflow_enable  <= pwdata[`B_T0_OVF_EN];
        ext_pin_irq_enable      <= pwdata[`B_EXT_EN];
        pin_change_enable       <= pwdata[`B_CHG_EN];
      end
      if (return_from_irq)
        global_irq_enable <= 1'b1; // [R18]
      if (irq_taken)
        global_irq_enable <= 1'b0; // [R17]
      // flags: a set in the clearing cycle wins
      if (wr_ctl)
        timer0_overflow_flag <= pwdata[`B_T0_OVF_FLAG];
      if (t0_roll)
        timer0_overflow_flag <= 1'b1; // [R7] [R20]
      if (wr_ctl)
        ext_pin_irq_flag <= pwdata[`B_EXT_FLAG];
      if (ext_evt)
        ext_pin_irq_flag <= 1'b1; // [R9] [R20]
      if (wr_pie)
        peripheral_irq_enable_one <= pwdata[7:0] & `PERIPH_EN_MASK; // [R16]
      if (wr_sel)
        pin_change_select_reg <= pwdata[PINS-1:0];
    end
  end

  // pin change flag: not reset, undefined until first write or event
  always @(posedge pclk) begin
    if (wr_ctl)
      pin_change_flag <= pwdata[`B_CHG_FLAG];
    if (pin_evt)
      pin_change_flag <= 1'b1; // [R10] [R20]
  end

  // timer0 counter holds through reset
  always @(posedge pclk) begin
    if (wr_cnt)
      timer0_counter <= pwdata[7:0]; // [R8]
    else if (timer0_tick)
      timer0_counter <= timer0_counter + `T0_COUNT_STEP;
  end

  // request gating
  wire [7:0] pie = peripheral_irq_enable_one;
  wire adc_hit  = pie[`B_ADC_EN]  & periph_flags[`B_ADC_EN];  // [R11]
  wire bcl_hit  = pie[`B_COLL_EN] & periph_flags[`B_COLL_EN]; // [R12]
  wire ssp_hit  = pie[`B_SER_EN]  & periph_flags[`B_SER_EN];  // [R13]
  wire tm2_hit  = pie[`B_T2_EN]   & periph_flags[`B_T2_EN];   // [R14]
  wire tm1_hit  = pie[`B_T1_EN]   & periph_flags[`B_T1_EN];   // [R15]
  wire per_hit  = peripheral_group_enable &
                  (adc_hit | bcl_hit | ssp_hit | tm2_hit | tm1_hit); // [R2] [R3]
  wire t0_hit   = timer0_overflow_enable & timer0_overflow_flag; // [R4]
  wire ext_hit  = ext_pin_irq_enable & ext_pin_irq_flag; // [R5]
  wire chg_hit  = pin_change_enable & pin_change_flag; // [R6]
  wire next_irq = global_irq_enable &
                  (t0_hit | ext_hit | chg_hit | per_hit); // [R1] [R21]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
      irq_vector  <= `IRQ_VECTOR;
    end else begin
      irq_request <= next_irq & ~irq_taken; // [R21]
      irq_vector  <= `IRQ_VECTOR; // [R17]
    end
  end

  // read mux
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(paddr, `OFF_CTRL))
      next_rdata[7:0] = {global_irq_enable, peripheral_group_enable,
                         timer0_overflow_enable, ext_pin_irq_enable,
                         pin_change_enable, timer0_overflow_flag,
                         ext_pin_irq_flag, pin_change_flag};
    else if (hit(paddr, `OFF_PERIPH_EN))
      next_rdata[7:0] = peripheral_irq_enable_one & `PERIPH_EN_MASK; // [R16]
    else if (hit(paddr, `OFF_PIN_SEL))
      next_rdata[PINS-1:0] = pin_change_select_reg;
    else if (hit(paddr, `OFF_T0_COUNT))
      next_rdata[7:0] = timer0_counter;
    else if (hit(paddr, `OFF_FLAG_VIEW))
      next_rdata[7:0] = periph_flags & `PERIPH_EN_MASK;
  end

  // one registered access cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ==== verif/irq_chk.sv ====
// irq_chk: port-level assertions for irq_ctl
// assumes one clock domain, bound onto every irq_ctl instance
`timescale 1ns/1ns
`default_nettype none
module irq_chk (
  // bus and core ports of irq_ctl
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_taken,
  input wire logic        return_from_irq,
  input wire logic        irq_request,
  input wire logic [12:0] irq_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire rd_en = setup && !pwrite && paddr == 8'h04;
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_needs_setup: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  a_err_unmapped: assert property (setup && paddr > 8'h10 |=> pslverr)
    else $error("unmapped access not refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unused_read_zero: assert property (
    rd_en |=> (prdata & 32'hffffff8c) == 32'h0)
    else $error("unused enable bits read nonzero");
  a_vector_fixed: assert property (irq_vector == 13'h0004)
    else $error("vector wrong");
  a_taken_drops_req: assert property (irq_taken |=> !irq_request)
    else $error("request after taken");
  a_masked_after_take: assert property (
    irq_taken ##1 (!return_from_irq && !(psel && pwrite))[*3]
    |-> !irq_request)
    else $error("request while global enable clear");
  cover property ($rose(irq_request));
  cover property (irq_taken);
  cover property (pslverr);
  cover property (return_from_irq ##[1:5] irq_request);
endmodule
bind irq_ctl irq_chk chk (.*);
`default_nettype wire

// ==== verif/core_model.sv ====
// core_model: core side, takes requests and returns from them
// assumes pclk domain; accept and ret_req come from the bench
`timescale 1ns/1ns
`default_nettype none
module core_model (
  // clock, reset and controls
  input  wire logic pclk, presetn, irq_request, accept, ret_req,
  // core pulses
  output var  logic irq_taken, return_from_irq
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_taken <= 1'b0;
      return_from_irq <= 1'b0;
    end else begin
      irq_taken <= accept && irq_request && !irq_taken;
      return_from_irq <= ret_req;
    end
  end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// testbench: drives irq_ctl over apb and its event inputs
// assumes core_model as the core and irq_chk bound in
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, timer0_tick;
  logic        ext_pin, ext_edge_select, accept, ret_req, err;
  logic [7:0]  paddr, periph_flags, pf, en;
  logic [5:0]  change_pins;
  logic [31:0] pwdata, q, d;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_taken, return_from_irq, irq_request;
  wire  [12:0] irq_vector;
  int          fail_count, n_checks, i;
  irq_ctl #(.PINS(6)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_tick(timer0_tick), .ext_pin(ext_pin),
    .ext_edge_select(ext_edge_select), .change_pins(change_pins),
    .periph_flags(periph_flags), .irq_taken(irq_taken),
    .return_from_irq(return_from_irq), .irq_request(irq_request),
    .irq_vector(irq_vector));
  core_model core (.pclk(pclk), .presetn(presetn),
    .irq_request(irq_request), .accept(accept), .ret_req(ret_req),
    .irq_taken(irq_taken), .return_from_irq(return_from_irq));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function logic exp_req(input logic [7:0] c, f, e);
    return c[7] & c[6] & (|(f & e & 8'h73));
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      print_verdict();
    end
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp, m);
    xfer(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask
  task req_is(input logic e);
    repeat (3) @(posedge pclk);
    chk(irq_request, e);
  endtask
  task wait6();
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, timer0_tick, ext_pin} = 5'h0;
    {ext_edge_select, accept, ret_req} = 3'h0;
    {paddr, periph_flags, change_pins, pwdata} = '0;
    presetn = 1'b0;
    void'($urandom(22730));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h00, 32'h0, 32'hfe);
    rdc(8'h04, 32'h0, 32'hff);
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom;
      wr(8'h04, d);
      rdc(8'h04, d & 32'h73, '1);
    end
    rdc(8'h3c, 32'h0, '1);
    chk(err, 1'b1);
    $display("test registers done");
    wr(8'h0c, 32'hff);
    wr(8'h00, 32'h0);
    timer0_tick <= 1'b1;
    @(posedge pclk);
    timer0_tick <= 1'b0;
    rdc(8'h00, 32'h04, 32'hff);
    rdc(8'h0c, 32'h0, 32'hff);
    wr(8'h00, 32'ha4);
    req_is(1'b1);
    accept <= 1'b1;
    req_is(1'b0);
    accept <= 1'b0;
    chk(irq_vector, 32'h4);
    rdc(8'h00, 32'h24, 32'hff);
    ret_req <= 1'b1;
    @(posedge pclk);
    ret_req <= 1'b0;
    req_is(1'b1);
    wr(8'h00, 32'h84);
    req_is(1'b0);
    wr(8'h0c, 32'h5a);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h0c, 32'h5a, 32'hff);
    rdc(8'h00, 32'h0, 32'hfe);
    $display("test timer0 done");
    ext_pin <= 1'b1;
    wait6();
    rdc(8'h00, 32'h0, 32'h02);
    ext_pin <= 1'b0;
    wait6();
    rdc(8'h00, 32'h02, 32'h02);
    wr(8'h00, 32'h92);
    req_is(1'b1);
    wr(8'h00, 32'h82);
    req_is(1'b0);
    ext_edge_select <= 1'b1;
    wr(8'h00, 32'h80);
    ext_pin <= 1'b1;
    wait6();
    rdc(8'h00, 32'h82, 32'hfe);
    $display("test ext pin done");
    wr(8'h08, 32'h01);
    change_pins <= 6'h02;
    wait6();
    rdc(8'h00, 32'h0, 32'h01);
    change_pins <= 6'h03;
    wait6();
    rdc(8'h00, 32'h01, 32'h01);
    req_is(1'b0);
    wr(8'h00, 32'h89);
    req_is(1'b1);
    $display("test pin change done");
    wr(8'h00, 32'h80);
    periph_flags <= 8'hff;
    wr(8'h04, 32'h73);
    req_is(1'b0);
    wr(8'h00, 32'hc0);
    for (i = 0; i < 16; i++) begin
      pf = (i < 8) ? 8'hff : 8'($urandom);
      en = (i < 8) ? (8'h01 << i) : 8'($urandom);
      periph_flags <= pf;
      wr(8'h04, {24'h0, en});
      req_is(exp_req(8'hc0, pf, en));
    end
    periph_flags <= 8'hff;
    wr(8'h04, 32'h73);
    req_is(1'b1);
    wr(8'h00, 32'h40);
    req_is(1'b0);
    rdc(8'h10, 32'h73, '1);
    $display("test peripherals done");
    print_verdict();
  end
endmodule
`default_nettype wire
